// File: logic/frt_fixed_ref_ctrl.sv
// Function
// R1: Ready flag at bit 6 reads one once the reference output is usable.
// R2: Ready flag stays zero while reference is disabled or still settling.
// R3: Bit 5 enables the die temperature sensor; zero disables it.
// R4: Bit 4 one selects sensor high range, zero selects low range.
// R5: Bits 3-2 decode 11 to 4x, 10 to 2x, else 1x peripheral level.
// R6: Sensor output routes internally to a converter input channel.
// R7: Bits 1-0 decode converter reference level with the same mapping.
`timescale 1ns/1ps
`default_nettype none

module frt_fixed_ref_ctrl
  import frt_pkg::*;
(
  input  wire logic        pclk,            // System clock
  input  wire logic        presetn,         // Async reset, active low
  input  wire logic        clk_en,          // Freezes all state when low
  input  wire logic        psel,            // APB select
  input  wire logic        penable,         // APB access phase
  input  wire logic        pwrite,          // APB write
  input  wire logic [11:0] paddr,           // APB byte address
  input  wire logic [31:0] pwdata,          // APB write data
  input  wire logic [3:0]  pstrb,           // APB byte strobes
  output logic      [31:0] prdata,          // APB read data
  output logic             pready,          // APB ready
  output logic             pslverr,         // APB error
  input  wire logic        ref_settled,     // Analog settled indication, async
  output logic             reference_enable,// Reference on
  output logic             temp_sense_enable, // Sensor on
  output logic             temp_range_select, // Sensor high range
  output logic [2:0]       periph_level,    // One-hot 1x/2x/4x peripheral level
  output logic [2:0]       conv_level,      // One-hot 1x/2x/4x converter level
  output logic             temp_to_adc_en   // Sensor onto converter channel
);
  import frt_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  // All state in one record, registered by a single process
  typedef struct packed {
    logic [7:0]  ctrl;
    logic [15:0] settle;
    logic [15:0] cnt;
    logic        sync1;
    logic        sync2;
    logic        ready;
    logic [31:0] rdata;
    logic        err;
    logic        done;
    logic [2:0]  plvl;
    logic [2:0]  clvl;
  } frt_state_t;

  frt_state_t st_q;
  frt_state_t st_d;

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  // Codes 01 and 00 share the lowest level
  function automatic logic [2:0] frt_level(input logic [1:0] code);
    if (code == 2'b11)
      frt_level = FRT_LVL_4X;
    else if (code == 2'b10)
      frt_level = FRT_LVL_2X;
    else
      frt_level = FRT_LVL_1X;
  endfunction

  // Whole-word match; no aliases in the map
  function automatic logic frt_hit(
    input logic [11:0] addr,
    input logic [11:0] offs
  );
    frt_hit = (addr == offs);
  endfunction

  // Ready bit is owned by hardware, writes to it are dropped
  function automatic logic [7:0] frt_ctrl_write(
    input logic [7:0] wdata
  );
    logic [7:0] val;
    val                = wdata;
    val[FRT_BIT_READY] = 1'b0;
    frt_ctrl_write     = val;
  endfunction

  // Byte-strobed update of a 16-bit register
  function automatic logic [15:0] frt_merge16(
    input logic [15:0] old_val,
    input logic [15:0] new_val,
    input logic [1:0]  strb
  );
    logic [15:0] merged;
    merged = old_val;
    if (strb[0])
      merged[7:0] = new_val[7:0];
    if (strb[1])
      merged[15:8] = new_val[15:8];
    frt_merge16 = merged;
  endfunction

  // Read word; unmapped offsets read as zero
  function automatic logic [31:0] frt_read_word(
    input logic        sel_ctrl,
    input logic        sel_dly,
    input logic [7:0]  ctrl,
    input logic        ready,
    input logic [15:0] settle
  );
    logic [31:0] word;
    word = 32'h0000_0000;
    if (sel_ctrl)
    begin
      word[7:0]           = ctrl;
      word[FRT_BIT_READY] = ready; // see R1
    end
    else if (sel_dly)
      word[15:0] = settle;
    frt_read_word = word;
  endfunction

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  // Upper strobes unused: both registers sit in the low half-word
  logic setup;
  logic access;
  logic hit_ctrl;
  logic hit_dly;

  assign setup    = psel && !penable;
  assign access   = psel && penable;
  assign hit_ctrl = frt_hit(paddr, FRT_CTRL_OFFS);
  assign hit_dly  = frt_hit(paddr, FRT_DELAY_OFFS);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    st_d       = st_q;
    // Only the second flop feeds logic
    st_d.sync1 = ref_settled;
    st_d.sync2 = st_q.sync1;
    st_d.done  = 1'b0;
    // Settling count restarts whenever the reference is off
    if (!st_q.ctrl[FRT_BIT_REF_EN])
    begin
      st_d.cnt   = 16'h0000;
      st_d.ready = 1'b0; // see R2
    end
    else
    begin
      if (st_q.cnt < st_q.settle)
        st_d.cnt = st_q.cnt + 16'h0001;
      // Needs both the timer and the analog flag
      st_d.ready = (st_q.cnt >= st_q.settle) && st_q.sync2; // see R1
    end

    // One wait state: decode in setup, answer in the second access cycle
    if (setup)
    begin
      st_d.err   = !(hit_ctrl || hit_dly);
      st_d.rdata = frt_read_word(hit_ctrl, hit_dly, st_q.ctrl, st_q.ready, st_q.settle); // see R1
    end
    // First access cycle only arms the answer
    if (access && !st_q.done)
      st_d.done = 1'b1;
    // Write lands on the edge where pready is seen high, as the master expects
    if (access && st_q.done && pwrite && !st_q.err)
    begin
      if (hit_ctrl && pstrb[0])
        st_d.ctrl = frt_ctrl_write(pwdata[7:0]); // see R3
      else if (hit_dly)
        st_d.settle = frt_merge16(st_q.settle, pwdata[15:0], pstrb[1:0]);
    end
    // Levels follow the next control value, so they move with the write
    st_d.plvl = frt_level(st_d.ctrl[FRT_PGAIN_LSB +: 2]); // see R5
    st_d.clvl = frt_level(st_d.ctrl[FRT_CGAIN_LSB +: 2]); // see R7
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q        <= '0;
      st_q.ctrl   <= FRT_CTRL_RESET;
      st_q.settle <= FRT_SETTLE_CYC;
      // Lowest level matches a zero control word
      st_q.plvl   <= FRT_LVL_1X;
      st_q.clvl   <= FRT_LVL_1X;
    end
    // Low enable freezes everything, bus handshake included
    else if (clk_en)
      st_q <= st_d;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign pready            = access && st_q.done;
  assign prdata            = st_q.rdata;
  assign pslverr           = access && st_q.done && st_q.err;

  // ----------------------------------------
  // Control outputs
  // ----------------------------------------
  assign reference_enable  = st_q.ctrl[FRT_BIT_REF_EN];
  assign temp_sense_enable = st_q.ctrl[FRT_BIT_TS_EN];    // see R3
  assign temp_range_select = st_q.ctrl[FRT_BIT_TS_RANGE]; // see R4
  assign periph_level      = st_q.plvl;                   // see R5
  assign conv_level        = st_q.clvl;                   // see R7
  // Internal route, no pin involved
  assign temp_to_adc_en    = st_q.ctrl[FRT_BIT_TS_EN];    // see R6

endmodule

`default_nettype wire

// File: logic/frt_pkg.sv
`default_nettype none
package frt_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [11:0] FRT_CTRL_OFFS  = 12'h000;
  localparam logic [11:0] FRT_DELAY_OFFS = 12'h004;

  // ----------------------------------------
  // Control register fields
  // ----------------------------------------
  localparam int FRT_BIT_REF_EN   = 7;
  localparam int FRT_BIT_READY    = 6;
  localparam int FRT_BIT_TS_EN    = 5;
  localparam int FRT_BIT_TS_RANGE = 4;
  localparam int FRT_PGAIN_LSB    = 2;
  localparam int FRT_CGAIN_LSB    = 0;

  localparam logic [7:0] FRT_CTRL_RESET = 8'h00;

  // ----------------------------------------
  // Gain levels, one-hot
  // ----------------------------------------
  localparam logic [2:0] FRT_LVL_1X = 3'h1;
  localparam logic [2:0] FRT_LVL_2X = 3'h2;
  localparam logic [2:0] FRT_LVL_4X = 3'h4;

  // ----------------------------------------
  // Reference settling time
  // ----------------------------------------
  localparam int          FRT_SETTLE_NS     = 1000;
  localparam int          FRT_CLK_PERIOD_NS = 8;
  localparam logic [15:0] FRT_SETTLE_CYC    =
    16'((FRT_SETTLE_NS + FRT_CLK_PERIOD_NS - 1) / FRT_CLK_PERIOD_NS);

endpackage

`default_nettype wire

// File: tb/fixed_ref_temp_sense_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module fixed_ref_temp_sense_control_tb;
  import frt_pkg::*;
  logic pclk=0, presetn=0, psel=0, penable=0, pwrite=0, clk_en=1, e, ref_settled, pready, pslverr;
  logic reference_enable, temp_sense_enable, temp_range_select, temp_to_adc_en;
  logic [2:0] periph_level, conv_level, x;
  logic [3:0] pstrb = 4'hf;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, r;
  int bad_count = 0, samples_checked = 0, n, k;
  always #4 pclk = ~pclk;
  frt_ref_model pm(.*);
  frt_fixed_ref_ctrl dut(.*);
  task final_report;
    $display("checked %0d bad %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] v, input string nm);
    samples_checked++;
    if (s !== v)
    begin
      $display("wrong value %s exp %h got %h", nm, v, s);
      bad_count++;
    end
  endtask
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk) penable <= 1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 9);
    if (pready !== 1'b1)
    begin
      bad_count++;
      final_report;
    end
    r = prdata; e = pslverr;
    psel <= 0; penable <= 0;
    @(posedge pclk);
  endtask
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    xfer(0, 12'h000, 0); chk(r, FRT_CTRL_RESET, "rst");
    xfer(1, 12'h004, 32'h0000_0004);
    xfer(0, 12'h004, 0); chk(r, 32'h0000_0004, "dly");
    for (int i = 0; i < 4; i++)
    begin
      x = i == 3 ? FRT_LVL_4X : i == 2 ? FRT_LVL_2X : FRT_LVL_1X;
      // Bit 6 written high too: must not stick
      xfer(1, 12'h000, 32'h0000_0040 | {i[1:0], i[1:0], i[1:0]});
      xfer(0, 12'h000, 0); chk(r, {i[1:0], i[1:0], i[1:0]}, "ctrl");
      chk({temp_sense_enable, temp_range_select, temp_to_adc_en, periph_level, conv_level},
        {i[1], i[0], i[1], x, x}, "out");
    end
    xfer(1, 12'h000, 32'h0000_0080);
    chk(reference_enable, 1, "en");
    k = 0;
    do xfer(0, 12'h000, 0); while (r[6] !== 1 && ++k < 20);
    chk(r, 32'h0000_00c0, "rdy");
    xfer(1, 12'h000, 0);
    repeat (4) @(posedge pclk);
    xfer(0, 12'h000, 0); chk(r, 0, "off");
    xfer(0, 12'h010, 0); chk(r, 0, "rd0"); chk(e, 1, "err");
    final_report;
  end
endmodule
`default_nettype wire

// File: tb/frt_ctrl_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module frt_ctrl_assertions(
  input wire logic pclk, // in
  input wire logic presetn, // in
  input wire logic psel, // in
  input wire logic penable, // in
  input wire logic pwrite, // in
  input wire logic [11:0] paddr, // in
  input wire logic [31:0] pwdata, // in
  input wire logic [3:0] pstrb, // in
  input wire logic [31:0] prdata, // in
  input wire logic pready, // in
  input wire logic reference_enable, // in
  input wire logic temp_sense_enable, // in
  input wire logic [2:0] periph_level, // in
  input wire logic [2:0] conv_level, // in
  input wire logic temp_to_adc_en // in
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire w = psel & penable & pready & pwrite & (paddr == 12'h000) & pstrb[0];
  wire rd = psel & penable & pready & !pwrite & (paddr == 12'h000);
  sequence su_s; psel & !penable; endsequence
  sequence ac_s; psel & penable; endsequence
  apb_wait_a: assert property(su_s ##1 ac_s |-> !pready ##1 pready) else $error("wait");
  adc_route_a: assert property(temp_to_adc_en == temp_sense_enable) else $error("route");
  ts_en_a: assert property(w |=> temp_sense_enable == $past(pwdata[5])) else $error("ts");
  pgain_map_a: assert property(w |=> periph_level ==
    {&$past(pwdata[3:2]), $past(pwdata[3:2]) == 2'h2, !$past(pwdata[3])}) else $error("pl");
  cgain_map_a: assert property(w |=> conv_level ==
    {&$past(pwdata[1:0]), $past(pwdata[1:0]) == 2'h2, !$past(pwdata[1])}) else $error("cl");
  plvl_hot_a: assert property($onehot(periph_level)) else $error("ph");
  clvl_hot_a: assert property($onehot(conv_level)) else $error("ch");
  rdy_ref_a: assert property(rd & prdata[6] |-> $past(reference_enable, 3)) else $error("rdy");
endmodule
bind frt_fixed_ref_ctrl frt_ctrl_assertions u_chk(.*);
`default_nettype wire

// File: tb/frt_ref_model.sv
`timescale 1ns/1ps
`default_nettype none
module frt_ref_model(
  input  wire logic pclk,             // Clock
  input  wire logic reference_enable, // Ref on
  output logic      ref_settled       // Settled
);
  // Analog settles a few cycles after power-up, drops at once
  logic [1:0] dly_q = 2'h0;
  always_ff @(posedge pclk) dly_q <= {dly_q[0], reference_enable};
  assign ref_settled = dly_q[1] & reference_enable;
endmodule
`default_nettype wire
